// [rtl/cad_datapath.sv]
// arithmetic datapath: alu with flags, multiplier, divider, shifter, status and core control
//
// What this block does
// - data addresses cover 32K words, 64 Kbytes byte addressed.
// - window on, upper 32 Kbytes map to program space at 8-bit page.
// - core control bit 2 enables the program window.
// - 17x17 multiplier finishes in one cycle, operands sign or zero extended.
// - multiply modes ss, uu, us, signed/unsigned by 5-bit literal, 8x8 unsigned.
// - divide runs in repeat loop, 19 cycles, pausing never loses partial result.
// - divide forms 32/16 and 16/16, each signed and unsigned.
// - quotient goes to work register zero, remainder to work register one.
// - one iteration per divisor bit, so both forms take equal cycles.
// - shifter does arithmetic/logic right or left up to 16 in one cycle.
// - signed amount: positive right, negative left, zero leaves operand.
// - 16-bit alu does add, subtract, shift, logic in two's complement.
// - add, subtract and logic work in byte or word width as instruction selects; shift is word only.
// - on subtraction carry and half carry act as borrow indicators.
// - half carry: carry out of bit 3 (byte) or bit 7 (word).
// - negative flag follows result sign.
// - signed wrap flag set when two's complement sign changes wrongly.
// - zero flag set on zero result, cleared on non-zero result.
// - carry flag set on carry out of result msb.
// - status bit 4 is read-only loop in progress indicator.
// - status bits 7-5 low priority bits, read-only while nesting disabled.
// - core control bit 3 top priority bit, software may only clear it.
`include "cad_defines.svh"

module cad_datapath
	import cad_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        op_valid,
	input  wire cad_op_t     op_code,
	input  wire cad_mul_t    mul_mode,
	input  wire logic        op_byte,
	input  wire logic        op_arith,
	input  wire logic [15:0] op_a,
	input  wire logic [15:0] op_b,
	input  wire logic [5:0]  op_shift,
	output logic      [15:0] res_lo,
	output logic      [15:0] res_hi,
	output logic             res_valid,
	input  wire logic        div_start,
	input  wire logic        div_step,
	input  wire logic        div_signed,
	input  wire logic        div_long,
	input  wire logic [15:0] div_hi,
	input  wire logic [15:0] div_lo,
	input  wire logic [15:0] div_sor,
	output logic             div_busy,
	output logic             div_done,
	output logic      [15:0] work_reg_zero,
	output logic      [15:0] work_reg_one,
	input  wire logic        da_valid,
	input  wire logic [15:0] da_addr,
	output logic             pw_hit,
	output logic      [21:0] pw_word,
	output logic      [14:0] dm_word,
	input  wire logic        loop_active,
	input  wire logic        nesting_disable,
	input  wire logic        priority_top_set,
	output logic      [15:0] cpu_status_flags,
	output logic      [15:0] core_control_reg
);

	cad_state_t s_reg;
	cad_state_t s_next;

	// ==========================================
	// adder, shifter, multiplier, divider step
	logic        is_sub;
	logic [15:0] b_eff;
	logic [16:0] sum17;
	logic [8:0]  sum9;
	logic [4:0]  sum5;
	logic [5:0]  sh_mag;
	logic [15:0] sh_res;
	logic [16:0] mul_a;
	logic [16:0] mul_b;
	logic [33:0] prod;
	logic [16:0] dv_sh;
	logic [17:0] dv_diff;
	logic [31:0] dv_ext;
	logic [31:0] dv_mag;
	logic        dv_neg;
	logic        sor_neg;

	assign is_sub  = (op_code == CAD_OP_SUB);
	// subtract as a + ~b + 1, so carry out high means no borrow
	assign b_eff   = is_sub ? ~op_b : op_b;
	assign sum17   = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, is_sub};
	assign sum9    = {1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, is_sub};
	assign sum5    = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};

	assign sh_mag  = op_shift[5] ? 6'(-op_shift) : op_shift;
	always_comb begin
		if (op_shift[5])
			sh_res = op_a << sh_mag;
		else if (op_arith)
			sh_res = 16'($signed(op_a) >>> sh_mag);
		else
			sh_res = op_a >> sh_mag;
	end

	// extension bit decides the sign treatment of each operand
	always_comb begin
		mul_a = {1'b0, op_a};
		mul_b = {1'b0, op_b};
		case (mul_mode)
			CAD_MUL_SS: begin
				mul_a = {op_a[15], op_a};
				mul_b = {op_b[15], op_b};
			end
			CAD_MUL_US:   mul_b = {op_b[15], op_b};
			CAD_MUL_SLIT: begin
				mul_a = {op_a[15], op_a};
				mul_b = {12'h000, op_b[`CAD_LIT_MSB:0]};
			end
			CAD_MUL_ULIT: mul_b = {12'h000, op_b[`CAD_LIT_MSB:0]};
			CAD_MUL_UU8:  begin
				mul_a = {9'h000, op_a[`CAD_BYTE_MSB:0]};
				mul_b = {9'h000, op_b[`CAD_BYTE_MSB:0]};
			end
			default: begin
				mul_a = {1'b0, op_a};
				mul_b = {1'b0, op_b};
			end
		endcase
	end
	// product is sized by the 34-bit target, so both signed operands extend before the multiply
	assign prod    = $signed(mul_a) * $signed(mul_b);

	// restoring step on magnitudes; signs are fixed in a last pass
	assign dv_sh   = {s_reg.drem, s_reg.dq[15]};
	assign dv_diff = {1'b0, dv_sh} - {2'b00, s_reg.dsor};
	assign dv_ext  = div_long ? {div_hi, div_lo} : {{16{div_signed & div_lo[15]}}, div_lo};
	assign dv_neg  = div_signed & dv_ext[31];
	assign dv_mag  = dv_neg ? 32'(-dv_ext) : dv_ext;
	assign sor_neg = div_signed & div_sor[15];

	// ==========================================
	// next state
	always_comb begin
		logic [15:0] r;
		logic        r_msb;
		r     = `CAD_RST_WORD;
		r_msb = 1'b0;
		s_next = s_reg;
		s_next.res_valid = 1'b0;
		s_next.div_done  = 1'b0;
		s_next.rdata     = `CAD_RST_WORD;
		s_next.pw_hit    = 1'b0;

		if (reg_rd) begin
			case (reg_addr)
				`CAD_OFF_STATUS: s_next.rdata = cpu_status_flags;
				`CAD_OFF_CORE:   s_next.rdata = core_control_reg;
				`CAD_OFF_PAGE:   s_next.rdata = {8'h00, s_reg.pw_page};
				default:         s_next.rdata = `CAD_RST_WORD;
			endcase
		end

		if (reg_wr) begin
			case (reg_addr)
				`CAD_OFF_STATUS: begin
					s_next.c  = reg_wdata[`CAD_SR_C];
					s_next.z  = reg_wdata[`CAD_SR_Z];
					s_next.ov = reg_wdata[`CAD_SR_OV];
					s_next.n  = reg_wdata[`CAD_SR_N];
					s_next.dc = reg_wdata[`CAD_SR_DC];
					if (!nesting_disable)
						s_next.ipl_low = reg_wdata[`CAD_SR_IPL_HI:`CAD_SR_IPL_LO];
				end
				`CAD_OFF_CORE: begin
					s_next.pw_en = reg_wdata[`CAD_CC_PWEN];
					if (!reg_wdata[`CAD_CC_IPLTOP])
						s_next.ipl_top = 1'b0;
				end
				`CAD_OFF_PAGE:   s_next.pw_page = reg_wdata[7:0];
				default: ;
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		if (priority_top_set)
			s_next.ipl_top = 1'b1;
		s_next.ra = loop_active;

		// data address split: upper half may be the program window
		if (da_valid) begin
			s_next.dm_word = da_addr[15:1];
			s_next.pw_hit  = s_reg.pw_en & da_addr[`CAD_WIN_BIT];
			s_next.pw_word = {s_reg.pw_page, da_addr[14:1]};
		end

		// flag updates come after software writes so the operation wins
		if (op_valid) begin
			s_next.res_valid = 1'b1;
			s_next.res_hi    = `CAD_RST_WORD;
			case (op_code)
				CAD_OP_ADD, CAD_OP_SUB: begin
					if (op_byte) begin
						r         = {8'h00, sum9[7:0]};
						r_msb     = sum9[`CAD_BYTE_MSB];
						s_next.c  = sum9[8];
						s_next.dc = sum5[4];
						s_next.ov = (op_a[7] == b_eff[7]) & (r_msb != op_a[7]);
					end else begin
						r         = sum17[15:0];
						r_msb     = sum17[15];
						s_next.c  = sum17[16];
						s_next.dc = sum9[8];
						s_next.ov = (op_a[15] == b_eff[15]) & (r_msb != op_a[15]);
					end
				end
				CAD_OP_AND, CAD_OP_IOR, CAD_OP_XOR: begin
					if (op_code == CAD_OP_AND)
						r = op_a & op_b;
					else if (op_code == CAD_OP_IOR)
						r = op_a | op_b;
					else
						r = op_a ^ op_b;
					if (op_byte)
						r = {8'h00, r[7:0]};
					r_msb = op_byte ? r[`CAD_BYTE_MSB] : r[15];
				end
				CAD_OP_SHIFT: begin
					r     = sh_res;
					r_msb = sh_res[15];
				end
				default: begin
					// multiply leaves every flag alone
					r             = prod[15:0];
					s_next.res_hi = prod[31:16];
				end
			endcase
			s_next.res_lo = r;
			if (op_code != CAD_OP_MUL) begin
				s_next.n = r_msb;
				s_next.z = (r == `CAD_RST_WORD);
			end
		end

		// divider advances only on a loop step, so a pause holds all state
		case (s_reg.dst)
			CAD_DIV_IDLE: begin
				if (div_start) begin
					s_next.drem = dv_mag[31:16];
					s_next.dq   = dv_mag[15:0];
					s_next.dsor = sor_neg ? 16'(-div_sor) : div_sor;
					s_next.qneg = dv_neg ^ sor_neg;
					s_next.rneg = dv_neg;
					s_next.dcnt = 5'h00;
					s_next.dst  = CAD_DIV_RUN;
				end
			end
			CAD_DIV_RUN: begin
				if (div_step) begin
					s_next.drem = dv_diff[17] ? dv_sh[15:0] : dv_diff[15:0];
					s_next.dq   = {s_reg.dq[14:0], ~dv_diff[17]};
					s_next.dcnt = s_reg.dcnt + 5'h01;
					if (s_reg.dcnt == (`CAD_DIV_ITER - 5'h01))
						s_next.dst = CAD_DIV_FIX;
				end
			end
			CAD_DIV_FIX: begin
				if (div_step) begin
					s_next.quot     = s_reg.qneg ? 16'(-s_reg.dq) : s_reg.dq;
					s_next.remd     = s_reg.rneg ? 16'(-s_reg.drem) : s_reg.drem;
					s_next.div_done = 1'b1;
					s_next.dst      = CAD_DIV_IDLE;
				end
			end
			default: s_next.dst = CAD_DIV_IDLE;
		endcase
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_reg         <= '0;
			s_reg.c       <= `CAD_RST_FLAG;
			s_reg.ipl_low <= `CAD_RST_IPL;
			s_reg.pw_page <= `CAD_RST_PAGE;
			s_reg.dst     <= CAD_DIV_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================
	// outputs, all straight from state bits
	assign reg_rdata        = s_reg.rdata;
	assign res_lo           = s_reg.res_lo;
	assign res_hi           = s_reg.res_hi;
	assign res_valid        = s_reg.res_valid;
	assign div_busy         = (s_reg.dst != CAD_DIV_IDLE);
	assign div_done         = s_reg.div_done;
	assign work_reg_zero    = s_reg.quot;
	assign work_reg_one     = s_reg.remd;
	assign pw_hit           = s_reg.pw_hit;
	assign pw_word          = s_reg.pw_word;
	assign dm_word          = s_reg.dm_word;
	assign cpu_status_flags = {7'h00, s_reg.dc, s_reg.ipl_low, s_reg.ra, s_reg.n, s_reg.ov, s_reg.z, s_reg.c};
	assign core_control_reg = {12'h000, s_reg.ipl_top, s_reg.pw_en, 2'b00};

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	logic [4:0] chk_steps;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			chk_steps <= 5'h00;
		else if (div_start && !div_busy)
			chk_steps <= 5'h00;
		else if (div_busy && div_step)
			chk_steps <= chk_steps + 5'h01;
	end

	sequence s_div_go;
		div_start && !div_busy;
	endsequence
	sequence s_div_pause;
		div_busy && !div_step;
	endsequence

	a_win_map: assert property (da_valid && core_control_reg[`CAD_CC_PWEN] && da_addr[15] |=>
		pw_hit && pw_word == {$past(s_reg.pw_page), $past(da_addr[14:1])})
		else $error("window address wrong");
	a_win_off: assert property (da_valid && !core_control_reg[`CAD_CC_PWEN] |=> !pw_hit)
		else $error("window hit while disabled");
	a_mul_uu: assert property (op_valid && op_code == CAD_OP_MUL && mul_mode == CAD_MUL_UU |=>
		res_valid && {res_hi, res_lo} == $past(op_a) * $past(op_b))
		else $error("unsigned product wrong");
	a_mul_flags: assert property (op_valid && op_code == CAD_OP_MUL && !reg_wr |=>
		$stable(cpu_status_flags[3:0]) && $stable(cpu_status_flags[`CAD_SR_DC]))
		else $error("multiply changed flags");
	a_div_start: assert property (s_div_go |=> div_busy && chk_steps == 5'h00)
		else $error("divide did not start");
	a_div_hold: assert property (s_div_pause ##1 div_busy |-> $stable(s_reg.drem) && $stable(s_reg.dq))
		else $error("paused divide lost state");
	a_div_len: assert property ($rose(div_done) |-> chk_steps == 5'(`CAD_DIV_ITER + 5'h01))
		else $error("divide step count wrong");
	a_zero_flag: assert property (op_valid && op_code == CAD_OP_ADD && !op_byte |=>
		cpu_status_flags[`CAD_SR_Z] == (res_lo == 16'h0000))
		else $error("zero flag wrong");
	a_top_clear: assert property (reg_wr && reg_addr == `CAD_OFF_CORE && !priority_top_set &&
		!core_control_reg[`CAD_CC_IPLTOP] |=> !core_control_reg[`CAD_CC_IPLTOP])
		else $error("software set priority top bit");
	a_shift_zero: assert property (op_valid && op_code == CAD_OP_SHIFT && op_shift == 6'h00 |=>
		res_lo == $past(op_a))
		else $error("zero shift changed operand");
	a_loop_flag: assert property (##1 cpu_status_flags[`CAD_SR_RA] == $past(loop_active))
		else $error("loop flag not tracking");
	a_sub_borrow: assert property (op_valid && op_code == CAD_OP_SUB && !op_byte |=>
		cpu_status_flags[`CAD_SR_C] == ($past(op_a) >= $past(op_b)))
		else $error("borrow flag wrong");
	a_half_carry: assert property (op_valid && op_code == CAD_OP_ADD && !op_byte |=>
		cpu_status_flags[`CAD_SR_DC] == ({1'b0, $past(op_a[7:0])} + {1'b0, $past(op_b[7:0])} > 9'h0ff))
		else $error("half carry flag wrong");
	a_ipl_lock: assert property (reg_wr && reg_addr == `CAD_OFF_STATUS && nesting_disable |=>
		$stable(cpu_status_flags[`CAD_SR_IPL_HI:`CAD_SR_IPL_LO]))
		else $error("priority bits written while locked");

endmodule : cad_datapath

// [rtl/cad_defines.svh]
// named offsets, bit positions, reset values and counts of the arithmetic datapath
`ifndef CAD_DEFINES_SVH
`define CAD_DEFINES_SVH

// ==========================================
// register offsets on the plain register port
`define CAD_OFF_STATUS   4'h0
`define CAD_OFF_CORE     4'h2
`define CAD_OFF_PAGE     4'h4

// ==========================================
// status register bit positions
`define CAD_SR_C         0
`define CAD_SR_Z         1
`define CAD_SR_OV        2
`define CAD_SR_N         3
`define CAD_SR_RA        4
`define CAD_SR_IPL_LO    5
`define CAD_SR_IPL_HI    7
`define CAD_SR_DC        8

// ==========================================
// core control bit positions
`define CAD_CC_PWEN      2
`define CAD_CC_IPLTOP    3

// ==========================================
// reset values
`define CAD_RST_FLAG     1'b0
`define CAD_RST_IPL      3'h0
`define CAD_RST_PAGE     8'h00
`define CAD_RST_WORD     16'h0000

// ==========================================
// datapath sizes and divide timing
`define CAD_BYTE_MSB     7
`define CAD_NIB_MSB      3
`define CAD_WIN_BIT      15
`define CAD_LIT_MSB      4
`define CAD_DIV_ITER     5'h10
`define CAD_DIV_TOTAL    19

`endif

// [rtl/cad_pkg.sv]
// types shared by the arithmetic datapath
package cad_pkg;

	// ==========================================
	// operation selects
	typedef enum logic [2:0] {
		CAD_OP_ADD   = 3'h0,
		CAD_OP_SUB   = 3'h1,
		CAD_OP_AND   = 3'h2,
		CAD_OP_IOR   = 3'h3,
		CAD_OP_XOR   = 3'h4,
		CAD_OP_SHIFT = 3'h5,
		CAD_OP_MUL   = 3'h6
	} cad_op_t;

	typedef enum logic [2:0] {
		CAD_MUL_SS   = 3'h0,
		CAD_MUL_UU   = 3'h1,
		CAD_MUL_US   = 3'h2,
		CAD_MUL_SLIT = 3'h3,
		CAD_MUL_ULIT = 3'h4,
		CAD_MUL_UU8  = 3'h5
	} cad_mul_t;

	typedef enum logic [2:0] {
		CAD_DIV_IDLE = 3'b001,
		CAD_DIV_RUN  = 3'b010,
		CAD_DIV_FIX  = 3'b100
	} cad_dst_t;

	// ==========================================
	// whole state of the datapath
	typedef struct packed {
		logic [15:0] rdata;
		logic        c;
		logic        z;
		logic        ov;
		logic        n;
		logic        dc;
		logic        ra;
		logic [2:0]  ipl_low;
		logic        ipl_top;
		logic        pw_en;
		logic [7:0]  pw_page;
		logic [15:0] res_lo;
		logic [15:0] res_hi;
		logic        res_valid;
		logic        pw_hit;
		logic [21:0] pw_word;
		logic [14:0] dm_word;
		cad_dst_t    dst;
		logic [4:0]  dcnt;
		logic [15:0] drem;
		logic [15:0] dq;
		logic [15:0] dsor;
		logic        qneg;
		logic        rneg;
		logic [15:0] quot;
		logic [15:0] remd;
		logic        div_done;
	} cad_state_t;

endpackage : cad_pkg

// [tb/cad_decoder_model.sv]
// decoder-side model: issues each divide as a repeat loop, with optional stalled steps
module cad_decoder_model
	import cad_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic go,
	input  wire logic slow,
	input  wire logic div_busy,
	output logic      div_start,
	output logic      div_step,
	output logic      loop_active
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_reg;
	logic       ph_reg;

	// ==========================================
	// repeat loop of 16 iterations plus the fix step
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_start   <= 1'b0;
			div_step    <= 1'b0;
			loop_active <= 1'b0;
			cnt_reg     <= 5'h00;
			ph_reg      <= 1'b0;
		end else begin
			ph_reg    <= !ph_reg;
			div_start <= go && !loop_active;
			if (go)
				cnt_reg <= 5'h00;
			else if (div_step)
				cnt_reg <= cnt_reg + 5'h01;
			// a stalled step stands in for an interrupt taken inside the loop
			div_step <= (div_start || div_busy) && (cnt_reg + 5'(div_step)) < 5'h11 && !(slow && ph_reg);
			if (go)
				loop_active <= 1'b1;
			else if (!div_start && !div_busy)
				loop_active <= 1'b0;
		end
	end
endmodule : cad_decoder_model

// [tb/tb_top.sv]
// self-checking bench of the arithmetic datapath with the decoder-side model
`include "cad_defines.svh"

module tb_top
	import cad_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0, op_byte = 1'b0;
	logic        op_arith = 1'b0, div_signed = 1'b0, div_long = 1'b0, da_valid = 1'b0, go = 1'b0, slow = 1'b0;
	logic        nesting_disable = 1'b0, priority_top_set = 1'b0, rd_d = 1'b0, da_d = 1'b0;
	logic        res_valid, div_start, div_step, div_busy, div_done, pw_hit, loop_active;
	logic [3:0]  reg_addr = 4'h0;
	logic [5:0]  op_shift = 6'h00;
	logic [14:0] dm_word;
	logic [21:0] pw_word;
	logic [15:0] reg_wdata = 16'h0000, op_a = 16'h0000, op_b = 16'h0000, div_hi = 16'h0000, div_lo = 16'h0000;
	logic [15:0] div_sor = 16'h0001, da_addr = 16'h0000, reg_rdata, res_lo, res_hi, work_reg_zero, work_reg_one;
	logic [15:0] cpu_status_flags, core_control_reg, exp_sr = 16'h0000, exp_cc = 16'h0000, exp_pg = 16'h0000;
	cad_op_t     op_code = CAD_OP_ADD;
	cad_mul_t    mul_mode = CAD_MUL_SS;
	logic [47:0] res_q[$], div_q[$], rd_q[$], da_q[$];
	int          fails = 0, tests_run = 0, busy_cnt = 0;

	cad_datapath cad_datapath_inst (.*);
	cad_decoder_model cad_decoder_model_inst (.*);

	always #25 clk_sys = !clk_sys;

	// ==========================================
	// compare and closing report
	task automatic chk(input logic [47:0] e, input logic [47:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// ==========================================
	// output watcher: oldest note against each result
	always @(posedge clk_sys) begin
		if (rd_d) chk(rd_q.pop_front(), {32'h0, reg_rdata});
		if (res_valid) chk(res_q.pop_front(), {16'h0, res_hi, res_lo});
		if (div_done) chk(div_q.pop_front(), {16'h0, work_reg_one, work_reg_zero});
		if (da_d) chk(da_q.pop_front(), {10'h0, pw_hit, pw_hit ? pw_word : 22'h0, dm_word});
		if (div_busy)
			busy_cnt++;
		rd_d <= reg_rd;
		da_d <= da_valid;
	end

	// ==========================================
	// drivers: every call re-drives all strobes, so back-to-back needs no gap
	task automatic strobe(input logic o, w, r, d);
		@(posedge clk_sys);
		op_valid <= o;
		reg_wr   <= w;
		reg_rd   <= r;
		da_valid <= d;
	endtask : strobe

	task automatic reg_acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		strobe(1'b0, w, !w, 1'b0);
		reg_addr  <= a;
		reg_wdata <= d;
		if (!w)
			rd_q.push_back({32'h0, a == 4'h0 ? exp_sr : a == 4'h2 ? exp_cc : a == 4'h4 ? exp_pg : 16'h0});
		else if (a == `CAD_OFF_STATUS)
			exp_sr = (d & 16'h010f) | (exp_sr & 16'h0010) | ((nesting_disable ? exp_sr : d) & 16'h00e0);
		else if (a == `CAD_OFF_CORE)
			exp_cc = {12'h0, exp_cc[3] & d[3], d[2], 2'b00};
		else if (a == `CAD_OFF_PAGE)
			exp_pg = {8'h0, d[7:0]};
	endtask : reg_acc

	task automatic do_op(input cad_op_t op, input cad_mul_t mm, input logic byt, ar, input logic [15:0] a, b,
			input logic [5:0] sh);
		logic [31:0] p;
		logic [16:0] s;
		logic [8:0]  s8;
		logic [4:0]  s4;
		logic [15:0] r, bb;
		logic        ci;
		byt = byt && op < CAD_OP_SHIFT;
		ci  = op == CAD_OP_SUB;
		bb  = ci ? ~b : b;
		s   = a + bb + ci;
		s8  = a[7:0] + bb[7:0] + ci;
		s4  = a[3:0] + bb[3:0] + ci;
		r   = op == CAD_OP_AND ? a & b : op == CAD_OP_IOR ? a | b : op == CAD_OP_XOR ? a ^ b : s[15:0];
		if (op == CAD_OP_SHIFT)
			r = $signed(sh) < 0 ? a << -$signed(sh) : ar ? 16'($signed(a) >>> sh) : a >> sh;
		if (byt)
			r = {8'h00, r[7:0]};
		case (mm)
			CAD_MUL_SS:   p = $signed(a) * $signed(b);
			CAD_MUL_UU:   p = a * b;
			CAD_MUL_US:   p = $signed({1'b0, a}) * $signed(b);
			CAD_MUL_SLIT: p = $signed(a) * $signed({1'b0, b[4:0]});
			CAD_MUL_ULIT: p = a * b[4:0];
			default:      p = a[7:0] * b[7:0];
		endcase
		if (op == CAD_OP_MUL)
			res_q.push_back({16'h0, p});
		else begin
			res_q.push_back({32'h0, r});
			exp_sr[3] = byt ? r[7] : r[15];
			exp_sr[1] = r == 16'h0;
		end
		if (op == CAD_OP_ADD || op == CAD_OP_SUB) begin
			exp_sr[0] = byt ? s8[8] : s[16];
			exp_sr[8] = byt ? s4[4] : s8[8];
			exp_sr[2] = byt ? (a[7] == bb[7] && r[7] != a[7]) : (a[15] == bb[15] && r[15] != a[15]);
		end
		strobe(1'b1, 1'b0, 1'b0, 1'b0);
		op_code  <= op;
		mul_mode <= mm;
		op_byte  <= byt;
		op_arith <= ar;
		op_a     <= a;
		op_b     <= b;
		op_shift <= sh;
	endtask : do_op

	task automatic do_div(input logic sg, lg, sl);
		logic [31:0] x, xe, q, rm;
		logic [15:0] d;
		int          k;
		d = 16'($urandom) | 16'h0001;
		x = $urandom;
		if (sg && d == 16'hffff)
			d = 16'h0003;
		// keep the quotient inside 16 bits, where the result is defined
		if (sg && lg) begin
			d[14] = !d[15];
			x     = {{4{x[27]}}, x[27:0]};
		end
		if (!sg && lg)
			x[31:16] = x[31:16] % d;
		xe = lg ? x : sg ? {{16{x[15]}}, x[15:0]} : {16'h0, x[15:0]};
		if (sg) begin
			q  = $signed(xe) / $signed({{16{d[15]}}, d});
			rm = $signed(xe) % $signed({{16{d[15]}}, d});
		end else begin
			q  = xe / d;
			rm = xe % d;
		end
		div_q.push_back({16'h0, rm[15:0], q[15:0]});
		// drop any strobe left standing by the previous task, so it is sampled only once
		strobe(1'b0, 1'b0, 1'b0, 1'b0);
		go         <= 1'b1;
		slow       <= sl;
		div_signed <= sg;
		div_long   <= lg;
		div_hi     <= lg ? x[31:16] : 16'($urandom);
		div_lo     <= x[15:0];
		div_sor    <= d;
		busy_cnt   = 0;
		@(posedge clk_sys);
		go <= 1'b0;
		exp_sr[4] = 1'b1;
		reg_acc(1'b0, `CAD_OFF_STATUS, 16'h0000);
		exp_sr[4] = 1'b0;
		strobe(1'b0, 1'b0, 1'b0, 1'b0);
		for (k = 0; k < 80 && div_done !== 1'b1; k++)
			@(negedge clk_sys);
		if (k == 80) begin
			fails++;
			test_done();
		end
		if (!sl)
			chk(48'h11, 48'(busy_cnt));
	endtask : do_div

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h67cb));
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i += 2)
			reg_acc(1'b0, 4'(i), 16'h0000);
		$display("test reset values done");
		reg_acc(1'b1, `CAD_OFF_CORE, 16'hffff);
		reg_acc(1'b1, `CAD_OFF_STATUS, 16'hffff);
		reg_acc(1'b1, `CAD_OFF_PAGE, 16'($urandom));
		nesting_disable <= 1'b1;
		reg_acc(1'b1, `CAD_OFF_STATUS, 16'h0000);
		priority_top_set <= 1'b1;
		strobe(1'b0, 1'b0, 1'b0, 1'b0);
		priority_top_set <= 1'b0;
		exp_cc[3] = 1'b1;
		for (int i = 0; i < 8; i += 2)
			reg_acc(1'b0, 4'(i), 16'h0000);
		@(negedge clk_sys);
		chk({32'h0, exp_sr}, {32'h0, cpu_status_flags});
		chk({32'h0, exp_cc}, {32'h0, core_control_reg});
		$display("test register access done");
		do_op(CAD_OP_ADD, CAD_MUL_SS, 1'b0, 1'b0, 16'h0001, 16'hffff, 6'h00);
		do_op(CAD_OP_SUB, CAD_MUL_SS, 1'b0, 1'b0, 16'h8000, 16'h0001, 6'h00);
		do_op(CAD_OP_ADD, CAD_MUL_SS, 1'b1, 1'b0, 16'h127f, 16'h0001, 6'h00);
		reg_acc(1'b0, `CAD_OFF_STATUS, 16'h0000);
		for (int i = -16; i <= 16; i += 16)
			do_op(CAD_OP_SHIFT, CAD_MUL_SS, 1'b0, 1'b1, 16'h8421, 16'h0000, 6'(i));
		for (int i = 0; i < 6; i++)
			do_op(CAD_OP_MUL, cad_mul_t'(i), 1'b0, 1'b0, 16'hfff3, 16'h8015, 6'h00);
		reg_acc(1'b0, `CAD_OFF_STATUS, 16'h0000);
		for (int i = 0; i < 60; i++) begin
			do_op(cad_op_t'($urandom_range(6)), cad_mul_t'($urandom_range(5)), 1'($urandom), 1'($urandom),
					16'($urandom), 16'($urandom), 6'($urandom_range(32) - 16));
			if (i % 3 == 0)
				reg_acc(1'b0, `CAD_OFF_STATUS, 16'h0000);
		end
		$display("test alu and flags done");
		reg_acc(1'b1, `CAD_OFF_CORE, 16'h0004);
		for (int i = 0; i < 8; i++)
			do_da(16'($urandom));
		reg_acc(1'b1, `CAD_OFF_CORE, 16'h0000);
		do_da(16'h8002);
		$display("test program window done");
		for (int i = 0; i < 8; i++)
			do_div(i[0], i[1], i[2]);
		$display("test divide done");
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({32'h0, exp_sr}, {32'h0, cpu_status_flags});
		chk({32'h0, exp_cc}, {32'h0, core_control_reg});
		test_done();
	end

	task automatic do_da(input logic [15:0] a);
		da_q.push_back({10'h0, exp_cc[2] & a[15], exp_cc[2] & a[15] ? {exp_pg[7:0], a[14:1]} : 22'h0, a[15:1]});
		strobe(1'b0, 1'b0, 1'b0, 1'b1);
		da_addr <= a;
	endtask : do_da
endmodule : tb_top
